// ### logic/fsec_dev.sv
`timescale 1ns/100ps
`include "fsec_consts.svh"
// Notes on behaviour
// - identity read: maker, type, capacity, msb first
// - table read: opcode, address, dummy, data clock 40
// - table read uses low address byte only
// - table read always takes three address bytes
// - three registers selected by address bits 15-12
// - erase needs write enable latch set
// - erase runs only if select rises on byte
// - erase is self-timed, busy reads one meanwhile
// - erase completion clears write enable latch
// - locked register ignores erase
// - program: opcode, address, data, latch set
// - program cycle starts when select rises after a data byte
// - locked register ignores program
// - secure read: opcode, address, dummy, msb first
// - read address wraps within the register
// - secure read ignored while busy
// - four address bytes in four-byte mode, except table read
module fsec_dev #(
   parameter int unsigned SEC_ERASE_CYCLES = `FS_SEC_ERASE_US * `FS_PCLK_MHZ,
   parameter logic [7:0]  MFR_ID           = `FS_MFR_ID_DEF,
   parameter logic [7:0]  MEMORY_TYPE_BYTE = `FS_MEM_TYPE_DEF,
   parameter logic [7:0]  CAPACITY_BYTE    = `FS_CAPACITY_DEF
) (
   input  wire logic       pclk,
   input  wire logic       presetn,
   fsec_if.dev             link,
   input  wire logic       four_byte_mode,
   input  wire logic [3:1] otp_lock_bits,
   output logic            busy,
   output logic            write_enable_latch
);

   localparam int unsigned SEC_PROG_CYCLES = `FS_SEC_PROG_US * `FS_PCLK_MHZ;

   logic [2:0]                     sclk_sy;
   logic [2:0]                     cs_sy;
   logic [1:0]                     mosi_sy;
   logic                           sclk_rise;
   logic                           sclk_fall;
   logic                           cs_hi;
   logic                           cs_rise;
   logic                           mosi_s;
   fsec_pkg::fsec_dev_phase_e      phase;
   logic [2:0]                     bitn;
   logic [6:0]                     shin;
   logic [7:0]                     rx_byte;
   logic                           byte_done;
   logic [7:0]                     opc;
   logic [31:0]                    addr;
   logic [31:0]                    next_addr;
   logic [2:0]                     abytes;
   logic                           prog_seen;
   logic [1:0]                     cmd_sel;
   logic [3:0]                     lock_vec;
   logic                           cmd_ok;
   logic [7:0]                     ptr;
   logic [7:0]                     out_byte;
   logic [2:0]                     obit;
   logic                           need_load;
   logic                           miso;
   logic [7:0]                     fetch;
   logic [23:0]                    timer;
   logic                           erasing;
   logic [1:0]                     esel;
   logic                           erase_done;
   logic [7:0]                     sec_mem [1:3][0:255];

   function automatic logic [1:0] sec_sel(input logic [31:0] a);
      if (a[31:16] == 16'h0000 && a[11:8] == 4'h0 && a[15:12] != 4'h0 && a[15:12] <= 4'h3) begin
         return a[13:12];
      end
      return 2'b00;
   endfunction : sec_sel

   // only a signature is held; the table contents live elsewhere
   function automatic logic [7:0] table_byte(input logic [7:0] p);
      case (p)
         8'h00: return 8'h53;
         8'h01: return 8'h46;
         8'h02: return 8'h44;
         8'h03: return 8'h50;
         default: return 8'hff;
      endcase
   endfunction : table_byte

   // the link clock is just another pin here, so all link inputs share one delay
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_sy <= 3'h0;
         cs_sy   <= 3'h7;
         mosi_sy <= 2'h0;
      end else begin
         sclk_sy <= {sclk_sy[1:0], link.sclk};
         cs_sy   <= {cs_sy[1:0], link.cs_n};
         mosi_sy <= {mosi_sy[0], link.mosi};
      end
   end

   assign sclk_rise  = sclk_sy[1] & ~sclk_sy[2];
   assign sclk_fall  = ~sclk_sy[1] & sclk_sy[2];
   assign cs_hi      = cs_sy[1];
   assign cs_rise    = cs_sy[1] & ~cs_sy[2];
   assign mosi_s     = mosi_sy[1];
   assign rx_byte    = {shin, mosi_s};
   assign byte_done  = (bitn == 3'h7);
   assign next_addr  = {addr[23:0], rx_byte};
   assign lock_vec   = {otp_lock_bits, 1'b1};
   assign cmd_ok     = write_enable_latch & ~lock_vec[sec_sel(next_addr)];
   assign erase_done = busy & erasing & (timer == 24'h0);
   assign link.miso  = miso;

   // command decode, sampled on link clock rising edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase     <= fsec_pkg::FSEC_PH_OPC;
         bitn      <= 3'h0;
         shin      <= 7'h00;
         opc       <= 8'h00;
         addr      <= 32'h0;
         abytes    <= 3'h0;
         prog_seen <= 1'b0;
         cmd_sel   <= 2'h0;
      end else if (cs_hi) begin
         phase     <= fsec_pkg::FSEC_PH_OPC;
         bitn      <= 3'h0;
         prog_seen <= 1'b0;
      end else if (sclk_rise) begin
         bitn <= bitn + 3'h1;
         shin <= {shin[5:0], mosi_s};
         if (phase == fsec_pkg::FSEC_PH_ARMED) begin
            phase <= fsec_pkg::FSEC_PH_IGNORE;
         end else if (byte_done) begin
            unique case (phase)
               fsec_pkg::FSEC_PH_OPC: begin
                  opc    <= rx_byte;
                  addr   <= 32'h0;
                  abytes <= four_byte_mode ? 3'h4 : 3'h3;
                  case (rx_byte)
                     `FS_OP_JEDEC_ID, `FS_OP_RD_STATUS: phase <= fsec_pkg::FSEC_PH_OUT;
                     `FS_OP_TABLE_RD: begin
                        phase  <= fsec_pkg::FSEC_PH_ADDR;
                        abytes <= 3'h3;
                     end
                     `FS_OP_SEC_ERASE, `FS_OP_SEC_PROG, `FS_OP_SEC_READ: begin
                        // a running cycle is never disturbed by these
                        phase <= busy ? fsec_pkg::FSEC_PH_IGNORE : fsec_pkg::FSEC_PH_ADDR;
                     end
                     default: phase <= fsec_pkg::FSEC_PH_IGNORE;
                  endcase
               end
               fsec_pkg::FSEC_PH_ADDR: begin
                  addr   <= next_addr;
                  abytes <= abytes - 3'h1;
                  if (abytes == 3'h1) begin
                     cmd_sel <= sec_sel(next_addr);
                     if (opc == `FS_OP_SEC_ERASE) begin
                        phase <= cmd_ok ? fsec_pkg::FSEC_PH_ARMED : fsec_pkg::FSEC_PH_IGNORE;
                     end else if (opc == `FS_OP_SEC_PROG) begin
                        phase <= cmd_ok ? fsec_pkg::FSEC_PH_DIN : fsec_pkg::FSEC_PH_IGNORE;
                     end else begin
                        phase <= fsec_pkg::FSEC_PH_DUMMY;
                     end
                  end
               end
               fsec_pkg::FSEC_PH_DUMMY: phase <= fsec_pkg::FSEC_PH_OUT;
               fsec_pkg::FSEC_PH_DIN: begin
                  addr[7:0] <= addr[7:0] + 8'h01;
                  prog_seen <= 1'b1;
               end
               fsec_pkg::FSEC_PH_OUT, fsec_pkg::FSEC_PH_ARMED, fsec_pkg::FSEC_PH_IGNORE: ;
            endcase
         end
      end
   end

   always_comb begin
      case (opc)
         `FS_OP_JEDEC_ID: fetch = (ptr == 8'h00) ? MFR_ID :
                                  (ptr == 8'h01) ? MEMORY_TYPE_BYTE : CAPACITY_BYTE;
         `FS_OP_RD_STATUS: fetch = {6'h00, write_enable_latch, busy};
         `FS_OP_TABLE_RD: fetch = table_byte(ptr);
         `FS_OP_SEC_READ: fetch = (cmd_sel != 2'h0) ? sec_mem[cmd_sel][ptr] : 8'hff;
         default: fetch = 8'hff;
      endcase
   end

   // output path: load a byte after it is chosen, shift it on falling edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ptr       <= 8'h00;
         out_byte  <= 8'hff;
         obit      <= 3'h0;
         need_load <= 1'b0;
         miso      <= 1'b0;
      end else if (cs_hi) begin
         need_load <= 1'b0;
         obit      <= 3'h0;
         miso      <= 1'b0;
      end else if (sclk_rise && byte_done && (phase == fsec_pkg::FSEC_PH_OPC ||
                   phase == fsec_pkg::FSEC_PH_ADDR || phase == fsec_pkg::FSEC_PH_DUMMY)) begin
         if (phase == fsec_pkg::FSEC_PH_OPC) begin
            ptr <= 8'h00;
         end else if (phase == fsec_pkg::FSEC_PH_ADDR) begin
            ptr <= rx_byte;
         end
         need_load <= (phase == fsec_pkg::FSEC_PH_DUMMY) || (phase == fsec_pkg::FSEC_PH_OPC &&
                      (rx_byte == `FS_OP_JEDEC_ID || rx_byte == `FS_OP_RD_STATUS));
         obit      <= 3'h0;
      end else if (need_load) begin
         out_byte  <= fetch;
         need_load <= 1'b0;
      end else if (sclk_fall && phase == fsec_pkg::FSEC_PH_OUT) begin
         miso <= out_byte[3'h7 - obit];
         obit <= obit + 3'h1;
         if (obit == 3'h7) begin
            need_load <= 1'b1;
            if (opc == `FS_OP_JEDEC_ID) begin
               ptr <= (ptr == 8'h02) ? 8'h00 : ptr + 8'h01;
            end else begin
               ptr <= ptr + 8'h01;
            end
         end
      end
   end

   // self-timed cycles; status stays readable because decode never waits on busy
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy               <= 1'b0;
         write_enable_latch <= 1'b0;
         timer              <= 24'h0;
         erasing            <= 1'b0;
         esel               <= 2'h0;
      end else if (busy) begin
         if (timer == 24'h0) begin
            busy               <= 1'b0;
            write_enable_latch <= 1'b0;
         end else begin
            timer <= timer - 24'h1;
         end
      end else if (cs_rise && phase == fsec_pkg::FSEC_PH_ARMED && bitn == 3'h0) begin
         busy    <= 1'b1;
         erasing <= 1'b1;
         esel    <= cmd_sel;
         timer   <= 24'(SEC_ERASE_CYCLES - 1);
      end else if (cs_rise && phase == fsec_pkg::FSEC_PH_DIN && prog_seen) begin
         busy    <= 1'b1;
         erasing <= 1'b0;
         timer   <= 24'(SEC_PROG_CYCLES - 1);
      end else if (!cs_hi && sclk_rise && byte_done && phase == fsec_pkg::FSEC_PH_OPC &&
                   rx_byte == `FS_OP_WR_ENABLE) begin
         write_enable_latch <= 1'b1;
      end
   end

   // programming only clears bits, as on a real one-time cell
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 1; i <= 3; i++) begin
            for (int j = 0; j < 256; j++) begin
               sec_mem[i][j] <= 8'hff;
            end
         end
      end else if (erase_done) begin
         for (int j = 0; j < 256; j++) begin
            sec_mem[esel][j] <= 8'hff;
         end
      end else if (!cs_hi && sclk_rise && byte_done && phase == fsec_pkg::FSEC_PH_DIN) begin
         sec_mem[cmd_sel][addr[7:0]] <= sec_mem[cmd_sel][addr[7:0]] & rx_byte;
      end
   end

endmodule : fsec_dev

// ### common/fsec_consts.svh
`ifndef FSEC_CONSTS_SVH
`define FSEC_CONSTS_SVH

`define FS_OP_JEDEC_ID   8'h9f
`define FS_OP_TABLE_RD   8'h5a
`define FS_OP_SEC_ERASE  8'h44
`define FS_OP_SEC_PROG   8'h42
`define FS_OP_SEC_READ   8'h48
`define FS_OP_WR_ENABLE  8'h06
`define FS_OP_RD_STATUS  8'h05

// identity bytes: arbitrary values
`define FS_MFR_ID_DEF    8'h5c
`define FS_MEM_TYPE_DEF  8'h41
`define FS_CAPACITY_DEF  8'h19

`define FS_PCLK_MHZ      50
`define FS_SEC_ERASE_US  100
`define FS_SEC_PROG_US   2
`define FS_HALF_CYC      4'h4

`define FS_REG_CTRL      8'h00
`define FS_REG_ADDR      8'h04
`define FS_REG_TXDATA    8'h08
`define FS_REG_RXDATA    8'h0c
`define FS_REG_STATUS    8'h10
`define FS_REG_IRQ_STAT  8'h14
`define FS_REG_IRQ_MASK  8'h18

`define FS_CTRL_HAS_ADDR 8
`define FS_CTRL_ADDR4    9
`define FS_CTRL_DUMMY    10
`define FS_CTRL_CNT_LSB  12
`define FS_CTRL_CNT_MSB  20
`define FS_CTRL_READ     21
`define FS_CTRL_START    31

`define FS_IRQ_DONE      0
`define FS_IRQ_TXREQ     1
`define FS_IRQ_RXRDY     2

`endif

// ### common/fsec_pkg.sv
package fsec_pkg;

   typedef enum logic [2:0] {
      FSEC_PH_OPC,
      FSEC_PH_ADDR,
      FSEC_PH_DUMMY,
      FSEC_PH_OUT,
      FSEC_PH_DIN,
      FSEC_PH_ARMED,
      FSEC_PH_IGNORE
   } fsec_dev_phase_e;

   typedef enum logic [2:0] {
      FSEC_HS_IDLE,
      FSEC_HS_LO,
      FSEC_HS_HI,
      FSEC_HS_WAIT,
      FSEC_HS_END
   } fsec_host_state_e;

endpackage : fsec_pkg

// ### common/fsec_if.sv
`timescale 1ns/100ps
interface fsec_if;
   logic sclk;
   logic cs_n;
   logic mosi;
   logic miso;

   modport dev (input sclk, input cs_n, input mosi, output miso);
   modport host (output sclk, output cs_n, output mosi, input miso);
endinterface : fsec_if

// ### logic/fsec_host.sv
`timescale 1ns/100ps
`include "fsec_consts.svh"
module fsec_host (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   fsec_if.host             link
);

   fsec_pkg::fsec_host_state_e state;
   logic [3:0]                 div;
   logic [2:0]                 bitn;
   logic [7:0]                 sh;
   logic [7:0]                 rsh;
   logic [8:0]                 byte_idx;
   logic [8:0]                 nxt_idx;
   logic [31:0]                ctrl_q;
   logic [31:0]                addr_reg;
   logic [31:0]                addr_sh;
   logic [2:0]                 na;
   logic [8:0]                 hdr;
   logic [8:0]                 total;
   logic                       rd;
   logic [7:0]                 tx_byte;
   logic                       tx_full;
   logic [7:0]                 rx_data;
   logic                       rx_full;
   logic [2:0]                 irq_stat;
   logic [2:0]                 irq_mask;
   logic [2:0]                 irq_ev;
   logic [1:0]                 miso_sy;
   logic                       sclk;
   logic                       cs_n;
   logic                       mosi;
   logic                       last_div;
   logic                       byte_end;
   logic                       wait_go;
   logic                       wr;
   logic                       start;

   function automatic logic mapped(input logic [7:0] a);
      return a <= `FS_REG_IRQ_MASK && a[1:0] == 2'h0;
   endfunction : mapped

   assign rd       = ctrl_q[`FS_CTRL_READ];
   assign na       = !ctrl_q[`FS_CTRL_HAS_ADDR] ? 3'h0 :
                     (ctrl_q[7:0] == `FS_OP_TABLE_RD || !ctrl_q[`FS_CTRL_ADDR4]) ? 3'h3 : 3'h4;
   assign hdr      = 9'h1 + 9'(na) + 9'(ctrl_q[`FS_CTRL_DUMMY]);
   assign total    = hdr + ctrl_q[`FS_CTRL_CNT_MSB:`FS_CTRL_CNT_LSB];
   assign nxt_idx  = byte_idx + 9'h1;
   assign last_div = (div == `FS_HALF_CYC - 4'h1);
   assign byte_end = (state == fsec_pkg::FSEC_HS_HI) && last_div && (bitn == 3'h7);
   assign wait_go  = (state == fsec_pkg::FSEC_HS_WAIT) && (rd ? !rx_full : tx_full);
   assign wr       = psel & penable & pwrite;
   assign start    = wr && paddr == `FS_REG_CTRL && pwdata[`FS_CTRL_START] && state == fsec_pkg::FSEC_HS_IDLE;
   assign pready   = 1'b1;
   assign pslverr  = psel & penable & ~mapped(paddr);
   assign irq      = |(irq_stat & irq_mask);
   assign link.sclk = sclk;
   assign link.cs_n = cs_n;
   assign link.mosi = mosi;

   assign irq_ev[`FS_IRQ_DONE]  = (state == fsec_pkg::FSEC_HS_END) && (div == {`FS_HALF_CYC, 1'b0} - 5'h1);
   assign irq_ev[`FS_IRQ_TXREQ] = byte_end && nxt_idx != total && nxt_idx >= hdr && !rd;
   assign irq_ev[`FS_IRQ_RXRDY] = byte_end && byte_idx >= hdr && rd;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         miso_sy <= 2'h0;
      end else begin
         miso_sy <= {miso_sy[0], link.miso};
      end
   end

   // the serial clock is divided down from pclk; it simply stops while waiting
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state    <= fsec_pkg::FSEC_HS_IDLE;
         div      <= 4'h0;
         bitn     <= 3'h0;
         sh       <= 8'h00;
         rsh      <= 8'h00;
         byte_idx <= 9'h0;
         ctrl_q   <= 32'h0;
         addr_sh  <= 32'h0;
         sclk     <= 1'b0;
         cs_n     <= 1'b1;
         mosi     <= 1'b0;
      end else begin
         unique case (state)
            fsec_pkg::FSEC_HS_IDLE: if (start) begin
               ctrl_q   <= {1'b0, pwdata[30:0]};
               cs_n     <= 1'b0;
               sh       <= pwdata[7:0];
               byte_idx <= 9'h0;
               bitn     <= 3'h0;
               div      <= 4'h0;
               state    <= fsec_pkg::FSEC_HS_LO;
               if (pwdata[7:0] == `FS_OP_TABLE_RD) begin
                  addr_sh <= {16'h0000, addr_reg[7:0], 8'h00};
               end else begin
                  addr_sh <= pwdata[`FS_CTRL_ADDR4] ? addr_reg : {addr_reg[23:0], 8'h00};
               end
            end
            fsec_pkg::FSEC_HS_LO: begin
               mosi <= sh[7];
               div  <= last_div ? 4'h0 : div + 4'h1;
               if (last_div) begin
                  sclk  <= 1'b1;
                  state <= fsec_pkg::FSEC_HS_HI;
               end
            end
            fsec_pkg::FSEC_HS_HI: begin
               div <= last_div ? 4'h0 : div + 4'h1;
               if (last_div) begin
                  // miso is taken late in the high half to cover the device's sync delay
                  sclk  <= 1'b0;
                  sh    <= {sh[6:0], 1'b0};
                  rsh   <= {rsh[6:0], miso_sy[1]};
                  bitn  <= bitn + 3'h1;
                  state <= fsec_pkg::FSEC_HS_LO;
                  if (bitn == 3'h7) begin
                     byte_idx <= nxt_idx;
                     if (nxt_idx == total) begin
                        state <= fsec_pkg::FSEC_HS_END;
                     end else if (nxt_idx >= hdr) begin
                        state <= fsec_pkg::FSEC_HS_WAIT;
                     end else if (nxt_idx <= 9'(na)) begin
                        sh      <= addr_sh[31:24];
                        addr_sh <= {addr_sh[23:0], 8'h00};
                     end else begin
                        sh <= 8'h00;
                     end
                  end
               end
            end
            fsec_pkg::FSEC_HS_WAIT: if (wait_go) begin
               sh    <= rd ? 8'hff : tx_byte;
               state <= fsec_pkg::FSEC_HS_LO;
            end
            fsec_pkg::FSEC_HS_END: begin
               div <= div + 4'h1;
               if (last_div) begin
                  cs_n <= 1'b1;
               end
               if (irq_ev[`FS_IRQ_DONE]) begin
                  state <= fsec_pkg::FSEC_HS_IDLE;
                  div   <= 4'h0;
               end
            end
         endcase
      end
   end

   // register side; hardware sets win over software clears
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_reg <= 32'h0;
         tx_byte  <= 8'h00;
         tx_full  <= 1'b0;
         rx_data  <= 8'h00;
         rx_full  <= 1'b0;
         irq_stat <= 3'h0;
         irq_mask <= 3'h0;
         prdata   <= 32'h0;
      end else begin
         if (wr && paddr == `FS_REG_ADDR) addr_reg <= pwdata;
         if (wr && paddr == `FS_REG_IRQ_MASK) irq_mask <= pwdata[2:0];
         if (wr && paddr == `FS_REG_TXDATA) begin
            tx_byte <= pwdata[7:0];
            tx_full <= 1'b1;
         end else if (wait_go && !rd) begin
            tx_full <= 1'b0;
         end
         if (irq_ev[`FS_IRQ_RXRDY]) begin
            rx_data <= {rsh[6:0], miso_sy[1]};
            rx_full <= 1'b1;
         end else if (psel && penable && !pwrite && paddr == `FS_REG_RXDATA) begin
            rx_full <= 1'b0;
         end
         irq_stat <= (irq_stat & ~((wr && paddr == `FS_REG_IRQ_STAT) ? pwdata[2:0] : 3'h0)) | irq_ev;
         if (psel && !penable) begin
            case (paddr)
               `FS_REG_CTRL: prdata <= ctrl_q;
               `FS_REG_ADDR: prdata <= addr_reg;
               `FS_REG_TXDATA: prdata <= {24'h0, tx_byte};
               `FS_REG_RXDATA: prdata <= {24'h0, rx_data};
               `FS_REG_STATUS: prdata <= {28'h0, state == fsec_pkg::FSEC_HS_WAIT, rx_full, tx_full,
                                          state != fsec_pkg::FSEC_HS_IDLE};
               `FS_REG_IRQ_STAT: prdata <= {29'h0, irq_stat};
               `FS_REG_IRQ_MASK: prdata <= {29'h0, irq_mask};
               default: prdata <= 32'h0;
            endcase
         end
      end
   end

endmodule : fsec_host

// ### tb/fsec_chk.sv
`timescale 1ns/100ps
module fsec_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso,
   input wire logic busy,
   input wire logic write_enable_latch
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_hi4; sclk [*4] ##1 !sclk; endsequence
   sequence s_busy_run; busy [*8] ##[1:400] !busy; endsequence
   property p_sclk_hi; $rose(sclk) |-> s_hi4; endproperty
   property p_cs_quiet; cs_n |-> !sclk; endproperty
   property p_miso_idle; cs_n [*4] |-> !miso; endproperty
   property p_miso_fall; !$stable(miso) && !cs_n |-> !sclk; endproperty
   property p_busy_cs; $rose(busy) |-> cs_n; endproperty
   property p_busy_run; $rose(busy) |-> s_busy_run; endproperty
   property p_wel_clr; $fell(busy) |-> !write_enable_latch; endproperty
   property p_wel_set; $rose(write_enable_latch) |-> !busy; endproperty
   property p_wel_hold; busy && $past(busy) |-> $stable(write_enable_latch); endproperty
   property p_mosi_hold; !cs_n && sclk |-> $stable(mosi); endproperty
   a_sclk_hi: assert property (p_sclk_hi) else $error("sclk high phase wrong");
   a_cs_quiet: assert property (p_cs_quiet) else $error("sclk moved outside frame");
   a_miso_idle: assert property (p_miso_idle) else $error("miso not low while deselected");
   a_miso_fall: assert property (p_miso_fall) else $error("miso changed while sclk high");
   a_busy_cs: assert property (p_busy_cs) else $error("busy rose inside a frame");
   a_busy_run: assert property (p_busy_run) else $error("busy length wrong");
   a_wel_clr: assert property (p_wel_clr) else $error("latch not cleared at cycle end");
   a_wel_set: assert property (p_wel_set) else $error("latch set while busy");
   a_wel_hold: assert property (p_wel_hold) else $error("latch moved during cycle");
   a_mosi_hold: assert property (p_mosi_hold) else $error("mosi changed while sclk high");
endmodule : fsec_chk

// ### tb/tb_top.sv
`timescale 1ns/100ps
`include "fsec_consts.svh"
module tb_top;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, four_byte_mode = 0;
   logic [7:0]  paddr = 8'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, irq, busy, write_enable_latch, err;
   logic [2:0]  lock = 3'h0;
   logic [7:0]  rxq[$];
   int          num_errors = 0, total_checks = 0, cyc = 0;
   fsec_if link ();
   fsec_host u_fsec_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .link(link));
   fsec_dev #(.SEC_ERASE_CYCLES(360)) u_fsec_dev (.pclk(pclk), .presetn(presetn), .link(link),
      .four_byte_mode(four_byte_mode), .otp_lock_bits(lock), .busy(busy), .write_enable_latch(write_enable_latch));
   fsec_chk u_fsec_chk (.pclk(pclk), .presetn(presetn), .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi),
      .miso(link.miso), .busy(busy), .write_enable_latch(write_enable_latch));
   always #10 pclk = ~pclk;
   // ceiling well above the ~6k cycles the frames need
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         num_errors++;
         print_verdict();
      end
   end
   task print_verdict;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : print_verdict
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      total_checks++;
      if (s !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb
   // read frames must drain each byte before the host clocks the next one
   task frame(input logic [31:0] ctrl, input logic [31:0] adr, input logic [7:0] d);
      apb(1'b1, `FS_REG_IRQ_STAT, 32'h7);
      rxq.delete();
      apb(1'b1, `FS_REG_ADDR, adr);
      apb(1'b1, `FS_REG_CTRL, ctrl | 32'h8000_0000);
      repeat (ctrl[20:12]) begin
         if (ctrl[21]) begin
            do apb(1'b0, `FS_REG_STATUS, 32'h0); while (rd[2] !== 1'b1);
            apb(1'b0, `FS_REG_RXDATA, 32'h0);
            rxq.push_back(rd[7:0]);
         end else begin
            do apb(1'b0, `FS_REG_STATUS, 32'h0); while (rd[1] !== 1'b0);
            apb(1'b1, `FS_REG_TXDATA, {24'h0, d});
         end
      end
      do apb(1'b0, `FS_REG_IRQ_STAT, 32'h0); while (rd[0] !== 1'b1);
   endtask : frame
   task chkq(input int n, input logic [31:0] e);
      for (int i = 0; i < n; i++) chk("rx byte", {24'h0, e[8*(n-1-i) +: 8]}, {24'h0, rxq[i]});
   endtask : chkq
   task t_ident;
      frame(32'h0020_409f, 32'h0, 8'h0);
      chkq(4, {`FS_MFR_ID_DEF, `FS_MEM_TYPE_DEF, `FS_CAPACITY_DEF, `FS_MFR_ID_DEF});
      four_byte_mode <= 1'b1;
      frame(32'h0020_375a, 32'h2, 8'h0);
      chkq(3, 32'h44_50ff);
      four_byte_mode <= 1'b0;
      $display("identity and table done");
   endtask : t_ident
   task t_prog;
      frame(32'h06, 32'h0, 8'h0);
      chk("latch", 32'h1, {31'h0, write_enable_latch});
      frame(32'h3142, 32'h10fe, 8'ha5);
      while (busy) @(posedge pclk);
      frame(32'h0020_4548, 32'h10fe, 8'h0);
      chkq(4, 32'ha5a5_a5ff);
      four_byte_mode <= 1'b1;
      frame(32'h0020_1748, 32'h1000, 8'h0);
      chkq(1, 32'ha5);
      four_byte_mode <= 1'b0;
      $display("program and read done");
   endtask : t_prog
   task t_lock;
      lock <= 3'h1;
      frame(32'h06, 32'h0, 8'h0);
      frame(32'h0144, 32'h1000, 8'h0);
      chk("busy locked erase", 32'h0, {31'h0, busy});
      frame(32'h1142, 32'h1001, 8'h00);
      frame(32'h0020_2548, 32'h1000, 8'h0);
      chkq(2, 32'ha5ff);
      lock <= 3'h0;
      frame(32'h1144, 32'h1000, 8'h0);
      chk("busy extra byte", 32'h0, {31'h0, busy});
      $display("lock done");
   endtask : t_lock
   task t_erase;
      frame(32'h0144, 32'h1000, 8'h0);
      chk("busy erase", 32'h1, {31'h0, busy});
      // status stays served mid-erase: latch and busy both read one
      frame(32'h0020_1005, 32'h0, 8'h0);
      chkq(1, 32'h03);
      frame(32'h0020_1548, 32'h10fe, 8'h0);
      chkq(1, 32'h0);
      while (busy) @(posedge pclk);
      chk("latch after", 32'h0, {31'h0, write_enable_latch});
      frame(32'h1142, 32'h1000, 8'h00);
      frame(32'h0020_3548, 32'h10fe, 8'h0);
      chkq(3, 32'hff_ffff);
      $display("erase done");
   endtask : t_erase
   task t_irq;
      chk("irq on", 32'h1, {31'h0, irq});
      apb(1'b1, `FS_REG_IRQ_MASK, 32'h0);
      // the write lands at the access edge, so look one edge later
      @(posedge pclk);
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'b1, `FS_REG_IRQ_MASK, 32'h1);
      apb(1'b1, `FS_REG_IRQ_STAT, 32'h7);
      @(posedge pclk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      apb(1'b0, 8'h1c, 32'h0);
      chk("unmapped", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
      $display("irq done");
   endtask : t_irq
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      apb(1'b1, `FS_REG_IRQ_MASK, 32'h1);
      t_ident();
      t_prog();
      t_lock();
      t_erase();
      t_irq();
      print_verdict();
   end
endmodule : tb_top
